// ### rtl/adcms_top.sv
`timescale 1ns/10ps
module adcms_top #(
  parameter logic [7:0][23:0] P_CONV_CYC = adcms_pkg::CONV_CYC,
  parameter int P_SCLK_TMO_CYC = adcms_pkg::SCLK_TMO_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_chip_select_low,
  input wire logic i_din,
  output logic o_data_out_ready_low,
  output logic o_data_out_ready_low_oe,
  output logic o_dout_pullup_en,
  input wire adcms_pkg::adcms_fe_t i_fe,
  output logic o_conv_start,
  output logic o_conv_active,
  output adcms_pkg::adcms_cfg_t o_cfg,
  output logic [15:0] o_conv_result
);
  import adcms_pkg::*;

  // ****************
  // Helpers
  // ****************
  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v > 18'sh07FFF) begin
      r = SAT_POS;
    end else if (v < -18'sh08000) begin
      r = SAT_NEG;
    end
    return r;
  endfunction

  function automatic logic keep_word(input logic [15:0] w);
    return (w == 16'h0000) || (w == 16'hFFFF);
  endfunction

  // ****************
  // Core-domain declarations
  // ****************
  adcms_cfg_t cfg_r;
  adcms_state_t st_r;
  logic [CONV_W-1:0] cnt_r;
  logic [CONV_W-1:0] period;
  logic [15:0] conv_r;
  logic [15:0] out_buf_r;
  logic new_data_r;
  logic pre_hi_r;
  logic start_r;
  logic ss_req;
  logic conv_done;
  logic wr_evt;
  logic rd_evt;
  logic [19:0] tmo_cnt_r;
  logic tmo_r;
  logic core_rst_r;
  logic sclk_s;
  logic busy_s;
  logic wr_tgl_s;
  logic rd_tgl_s;
  logic wr_tgl_d_r;
  logic rd_tgl_d_r;
  logic sclk_tgl_d_r;

  // ****************
  // Link-domain declarations
  // ****************
  logic link_arst;
  logic [5:0] rise_cnt_r;
  logic [5:0] fall_cnt_r;
  logic [31:0] shreg_r;
  logic [15:0] din_sr_r;
  logic [15:0] wr_data_r;
  logic wr_tgl_r;
  logic rd_tgl_r;
  logic sclk_tgl_r;
  logic started;

  // ****************
  // Link: clock activity toggle
  // ****************
  always_ff @(posedge i_sclk or posedge core_rst_r) begin
    if (core_rst_r) begin
      sclk_tgl_r <= 1'b0;
    end else begin
      sclk_tgl_r <= !sclk_tgl_r;
    end
  end

  // ****************
  // Crossings into core
  // ****************
  adcms_sync #(.W(4)) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d({sclk_tgl_r, started, wr_tgl_r, rd_tgl_r}),
    .o_q({sclk_s, busy_s, wr_tgl_s, rd_tgl_s})
  );

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wr_tgl_d_r <= 1'b0;
      rd_tgl_d_r <= 1'b0;
      sclk_tgl_d_r <= 1'b0;
    end else begin
      wr_tgl_d_r <= wr_tgl_s;
      rd_tgl_d_r <= rd_tgl_s;
      sclk_tgl_d_r <= sclk_s;
    end
  end

  assign wr_evt = wr_tgl_s ^ wr_tgl_d_r;
  assign rd_evt = rd_tgl_s ^ rd_tgl_d_r;

  // ****************
  // Configuration register
  // ****************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cfg_r <= CFG_RST;
    end else if (wr_evt && !keep_word(wr_data_r)) begin
      cfg_r <= wr_data_r;
      cfg_r.ss <= 1'b0;
    end
  end

  assign ss_req = wr_evt && !keep_word(wr_data_r) && wr_data_r[15];

  // ****************
  // Conversion sequencer
  // ****************
  assign period = P_CONV_CYC[cfg_r.data_rate_select];
  assign conv_done = (st_r == ST_CONV) && (cnt_r >= period - 24'h000001);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_r <= ST_PDN;
      cnt_r <= '0;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      case (st_r)
        ST_PDN: begin
          cnt_r <= '0;
          if (!cfg_r.mode || ss_req) begin
            st_r <= ST_CONV;
            start_r <= 1'b1;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            cnt_r <= '0;
            if (cfg_r.mode) begin
              st_r <= ST_PDN;
            end else begin
              start_r <= 1'b1;
            end
          end else begin
            cnt_r <= cnt_r + 24'h000001;
          end
        end
        default: begin
          st_r <= ST_PDN;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // ****************
  // Result capture
  // ****************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      conv_r <= CONV_RST;
    end else if (conv_done) begin
      if (cfg_r.temperature_mode_select) begin
        conv_r <= {i_fe.temp, 2'b00};
      end else begin
        conv_r <= sat16(i_fe.sum);
      end
    end
  end

  // ****************
  // Output buffer for the link
  // ****************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      out_buf_r <= CONV_RST;
    end else if (!busy_s) begin
      out_buf_r <= conv_r;
    end
  end

  // ****************
  // Ready tracking
  // ****************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      new_data_r <= 1'b0;
    end else if (conv_done) begin
      new_data_r <= 1'b1;
    end else if (rd_evt) begin
      new_data_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pre_hi_r <= 1'b0;
    end else begin
      pre_hi_r <= !cfg_r.mode && (st_r == ST_CONV) && new_data_r && !conv_done
                  && (cnt_r + 24'(PRE_RDY_CYC) >= period);
    end
  end

  // ****************
  // Serial clock time-out
  // ****************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tmo_cnt_r <= '0;
      tmo_r <= 1'b0;
    end else begin
      tmo_r <= 1'b0;
      if (sclk_s ^ sclk_tgl_d_r) begin
        tmo_cnt_r <= '0;
      end else if (tmo_cnt_r < 20'(P_SCLK_TMO_CYC)) begin
        tmo_cnt_r <= tmo_cnt_r + 20'h00001;
        tmo_r <= (tmo_cnt_r == 20'(P_SCLK_TMO_CYC - 1));
      end
    end
  end

  always_ff @(posedge i_clk) begin
    core_rst_r <= !i_nrst;
  end

  assign link_arst = i_chip_select_low | tmo_r | core_rst_r;

  // ****************
  // Link: rising edge shifter
  // ****************
  always_ff @(posedge i_sclk or posedge link_arst) begin
    if (link_arst) begin
      rise_cnt_r <= '0;
      shreg_r <= '0;
    end else begin
      if (rise_cnt_r != BITS_FULL) begin
        rise_cnt_r <= rise_cnt_r + 6'h01;
      end
      if (rise_cnt_r == 6'h00) begin
        shreg_r <= {out_buf_r, 16'h0000};
      end else if (rise_cnt_r == BITS_HALF) begin
        if (keep_word(din_sr_r)) begin
          shreg_r <= {cfg_r, 16'h0000};
        end else begin
          shreg_r <= {1'b0, din_sr_r[14:0], 16'h0000};
        end
      end else begin
        shreg_r <= {shreg_r[30:0], 1'b0};
      end
    end
  end

  assign started = (rise_cnt_r != 6'h00);

  // ****************
  // Link: falling edge sampler
  // ****************
  always_ff @(negedge i_sclk or posedge link_arst) begin
    if (link_arst) begin
      fall_cnt_r <= '0;
      din_sr_r <= '0;
    end else begin
      if (fall_cnt_r != BITS_FULL) begin
        fall_cnt_r <= fall_cnt_r + 6'h01;
      end
      if (fall_cnt_r < BITS_HALF) begin
        din_sr_r <= {din_sr_r[14:0], i_din};
      end
    end
  end

  // ****************
  // Link: events toward core
  // ****************
  always_ff @(negedge i_sclk or posedge core_rst_r) begin
    if (core_rst_r) begin
      wr_data_r <= '0;
      wr_tgl_r <= 1'b0;
      rd_tgl_r <= 1'b0;
    end else if (!link_arst && fall_cnt_r == BITS_HALF - 6'h01) begin
      wr_data_r <= {din_sr_r[14:0], i_din};
      wr_tgl_r <= !wr_tgl_r;
      rd_tgl_r <= !rd_tgl_r;
    end
  end

  // ****************
  // Data-out / ready pin
  // ****************
  always_comb begin
    o_data_out_ready_low_oe = !i_chip_select_low;
    if (started) begin
      o_data_out_ready_low = shreg_r[31];
    end else begin
      o_data_out_ready_low = !(new_data_r && !pre_hi_r);
    end
  end

  assign o_dout_pullup_en = i_chip_select_low && cfg_r.pull_up_en;

  // ****************
  // Front-end controls
  // ****************
  assign o_conv_start = start_r;
  assign o_conv_active = (st_r == ST_CONV);
  assign o_cfg = cfg_r;
  assign o_conv_result = conv_r;

endmodule

// ### rtl/adcms_pkg.sv
// Function
// - Temperature mode returns 14-bit two's-complement code left-aligned, 0.03125 C per count.
// - Reset loads every configuration bit with its default value.
// - After reset the converter idles powered down; serial port still answers.
// - Mode 1: start bit triggers one conversion, then back to power-down.
// - Start bit written during a running conversion is ignored.
// - Mode 0: each result is stored and the next conversion starts at once.
// - Writing mode 1 or a reset ends continuous conversion.
// - Four-wire or three-wire use; host holds chip select low during transfers.
// - Chip select high resets serial logic, ignores clock, releases data pin.
// - Chip select falling drives pin low for unread data, else high.
// - Result in the shift register stays fixed until the transfer ends.
// - Serial clock low for 28 ms resets the serial logic.
// - Data input sampled on falling clock edges and never driven.
// - Next output bit changes on each rising clock edge.
// - Data pin pulled low signals a new unread result.
// - Continuous mode, unread data: pin high 8 us before next ready.
// - Chip select high: weak pull-up by default, removed when enable is 0.
// - Results are 16-bit two's complement, clipped at 7FFF and 8000.
// - Start bit always reads back as zero.
// - Result bit 15 goes out first on the first rising edge, MSB first.
// - Configuration written in the first two bytes returns in the last two.
package adcms_pkg;

  // ****************
  // Configuration word
  // ****************
  typedef struct packed {
    logic ss;
    logic [2:0] mux;
    logic [2:0] pga;
    logic mode;
    logic [2:0] data_rate_select;
    logic temperature_mode_select;
    logic pull_up_en;
    logic [2:0] rsvd;
  } adcms_cfg_t;

  localparam logic [15:0] CFG_RST = 16'h058B;
  localparam int CFG_W = 16;

  // ****************
  // Front-end sample
  // ****************
  typedef struct packed {
    logic signed [17:0] sum;
    logic [13:0] temp;
  } adcms_fe_t;

  localparam logic [15:0] CONV_RST = 16'h0000;
  localparam logic [15:0] SAT_POS = 16'h7FFF;
  localparam logic [15:0] SAT_NEG = 16'h8000;

  // ****************
  // Timing
  // ****************
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_NS = 40;
  localparam int PRE_RDY_NS = 8000;
  localparam int PRE_RDY_CYC = (PRE_RDY_NS / CLK_NS < 1) ? 1 : PRE_RDY_NS / CLK_NS;
  localparam int SCLK_TMO_MS = 28;
  localparam int SCLK_TMO_CYC = SCLK_TMO_MS * (CLK_HZ / 1000);
  localparam int CONV_W = 24;
  localparam int ODR_0 = 5;
  localparam int ODR_1 = 10;
  localparam int ODR_2 = 20;
  localparam int ODR_3 = 50;
  localparam int ODR_4 = 100;
  localparam int ODR_5 = 200;
  localparam int ODR_6 = 480;
  localparam int ODR_7 = 960;
  localparam logic [7:0][CONV_W-1:0] CONV_CYC = {
    24'(CLK_HZ / ODR_7), 24'(CLK_HZ / ODR_6), 24'(CLK_HZ / ODR_5), 24'(CLK_HZ / ODR_4),
    24'(CLK_HZ / ODR_3), 24'(CLK_HZ / ODR_2), 24'(CLK_HZ / ODR_1), 24'(CLK_HZ / ODR_0)};

  // ****************
  // Serial framing
  // ****************
  localparam logic [5:0] BITS_HALF = 6'h10;
  localparam logic [5:0] BITS_FULL = 6'h20;

  typedef enum logic {
    ST_PDN = 1'b0,
    ST_CONV = 1'b1
  } adcms_state_t;

endpackage

// ### rtl/adcms_sync.sv
`timescale 1ns/10ps
module adcms_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  // ****************
  // Two-stage synchroniser
  // ****************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule

// ### sim/adcms_asserts.sv
`timescale 1ns/10ps
module adcms_asserts #(
  parameter logic [7:0][23:0] P_CONV_CYC = adcms_pkg::CONV_CYC,
  parameter int P_SCLK_TMO_CYC = adcms_pkg::SCLK_TMO_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_chip_select_low,
  input wire logic i_din,
  input wire logic o_data_out_ready_low,
  input wire logic o_data_out_ready_low_oe,
  input wire logic o_dout_pullup_en,
  input wire adcms_pkg::adcms_fe_t i_fe,
  input wire logic o_conv_start,
  input wire logic o_conv_active,
  input wire adcms_pkg::adcms_cfg_t o_cfg,
  input wire logic [15:0] o_conv_result
);
  import adcms_pkg::*;
  logic [23:0] cnt_r;
  logic [23:0] lim;
  assign lim = P_CONV_CYC[o_cfg.data_rate_select];
  // ****************
  // Conversion timer
  // ****************
  always_ff @(posedge i_clk) begin
    if (!i_nrst || o_conv_start) begin
      cnt_r <= 24'h0;
    end else begin
      cnt_r <= cnt_r + 24'h1;
    end
  end
  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  rst_dflt_a: assert property (disable iff (1'b0) $rose(i_nrst) |-> o_cfg == 16'h058B && !o_conv_active)
    else $error("reset defaults wrong");
  oe_sel_a: assert property (o_data_out_ready_low_oe == !i_chip_select_low)
    else $error("pin enable wrong");
  pull_up_a: assert property (o_dout_pullup_en == (i_chip_select_low && o_cfg.pull_up_en))
    else $error("pull-up wrong");
  ss_busy_a: assert property (o_conv_start && o_cfg.mode && $past(o_cfg.mode) |-> !$past(o_conv_active))
    else $error("start while busy");
  start_act_a: assert property (o_conv_start |-> o_conv_active ##1 !o_conv_start)
    else $error("start pulse wrong");
  conv_len_a: assert property ($fell(o_conv_active) |-> cnt_r + 24'h3 >= lim && cnt_r <= lim + 24'h3)
    else $error("conversion length wrong");
  ss_stop_a: assert property ($fell(o_conv_active) |-> o_cfg.mode)
    else $error("stopped in continuous mode");
  cont_run_a: assert property (!o_cfg.mode && !$past(o_cfg.mode) && !o_conv_active |-> ##[1:4] o_conv_active)
    else $error("continuous mode idle");
  res_upd_a: assert property ($changed(o_conv_result) |-> $past(o_conv_active) || $past(o_conv_active, 2))
    else $error("result changed outside conversion");
endmodule
bind adcms_top adcms_asserts #(.P_CONV_CYC(P_CONV_CYC), .P_SCLK_TMO_CYC(P_SCLK_TMO_CYC)) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_sclk(i_sclk), .i_chip_select_low(i_chip_select_low), .i_din(i_din),
  .o_data_out_ready_low(o_data_out_ready_low), .o_data_out_ready_low_oe(o_data_out_ready_low_oe),
  .o_dout_pullup_en(o_dout_pullup_en), .i_fe(i_fe), .o_conv_start(o_conv_start),
  .o_conv_active(o_conv_active), .o_cfg(o_cfg), .o_conv_result(o_conv_result));

// ### sim/adcms_host.sv
`timescale 1ns/10ps
module adcms_host (
  input wire logic i_pin,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  // ****************
  // Serial master
  // ****************
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  task automatic sel(input logic v);
    o_cs_n = v;
  endtask
  task automatic frame(input logic [15:0] w, input int n, output logic [31:0] r);
    r = '0;
    #7.5;
    for (int k = 0; k < n; k++) begin
      o_sclk = 1'b1;
      o_din = w[15 - k % 16] & (k < 16);
      #3;
      r = {r[30:0], i_pin};
      o_sclk = 1'b0;
      #3;
    end
  endtask
endmodule

// ### sim/tb_adcms_top.sv
`timescale 1ns/10ps
module tb_adcms_top;
  import adcms_pkg::*;
  logic i_clk;
  logic i_nrst;
  logic sclk, cs_n, din, dout, oe, pu, cst, act;
  adcms_fe_t fe;
  adcms_cfg_t cfg;
  logic [15:0] res;
  logic [31:0] rd;
  int starts;
  int mismatches;
  int comparisons;
  wire pin;
  assign pin = oe ? dout : (pu ? 1'b1 : 1'bz);
  adcms_top #(.P_CONV_CYC({8{24'h190}}), .P_SCLK_TMO_CYC(300)) DUT (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_sclk(sclk), .i_chip_select_low(cs_n), .i_din(din),
    .o_data_out_ready_low(dout), .o_data_out_ready_low_oe(oe), .o_dout_pullup_en(pu), .i_fe(fe),
    .o_conv_start(cst), .o_conv_active(act), .o_cfg(cfg), .o_conv_result(res));
  adcms_host u_host (.i_pin(pin), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
  // ****************
  // Helpers
  // ****************
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (cst === 1'b1) begin
      starts++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic xfer(input logic [15:0] w, input int n, input logic e);
    cyc(1);
    u_host.sel(1'b0);
    cyc(1);
    chk(pin, e);
    u_host.frame(w, n, rd);
    cyc(1);
    u_host.sel(1'b1);
    cyc(6);
  endtask
  task automatic wait_on(input logic v);
    int k;
    k = 0;
    while ((v ? cst : act) !== v && k < 1000) begin
      cyc(1);
      k++;
    end
    chk(v ? cst : act, v);
    cyc(1);
  endtask
  initial begin
    #1_000_000;
    mismatches++;
    report_and_stop();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    logic [17:0] sums [3];
    logic [15:0] exps [3];
    sums = '{18'h09C40, 18'h363C0, 18'h004D2};
    exps = '{16'h7FFF, 16'h8000, 16'h04D2};
    fe = '0;
    i_nrst = 1'b0;
    mismatches = 0;
    comparisons = 0;
    starts = 0;
    cyc(12);
    i_nrst = 1'b1;
    cyc(20);
    chk(cfg, 16'h058B);
    chk({act, res}, 17'h0);
    chk(starts, 0);
    chk({oe, pu}, 2'h1);
    for (int k = 0; k < 3; k++) begin
      fe.sum = sums[k];
      starts = 0;
      xfer(16'h8583, 32, 1'b1);
      chk(rd, {exps[(k + 2) % 3] & {16{k > 0}}, 16'h0583});
      chk({oe, pu}, 2'h0);
      xfer(16'h8583, 16, 1'b1);
      wait_on(1'b0);
      cyc(20);
      chk({starts[3:0], act}, 5'h2);
      chk(res, exps[k]);
      xfer(16'h0000, 16, 1'b0);
      chk(rd[15:0], exps[k]);
    end
    fe.temp = 14'h3CE0;
    xfer(16'h0493, 16, 1'b1);
    wait_on(1'b1);
    wait_on(1'b1);
    u_host.sel(1'b0);
    cyc(150);
    chk(pin, 1'b0);
    cyc(100);
    chk(pin, 1'b1);
    wait_on(1'b1);
    cyc(3);
    chk({pin, res}, 17'h0F380);
    xfer(16'h0593, 16, 1'b0);
    chk(rd[15:0], 16'hF380);
    wait_on(1'b0);
    cyc(30);
    chk(act, 1'b0);
    u_host.sel(1'b0);
    u_host.frame(16'h0000, 5, rd);
    cyc(320);
    u_host.frame(16'h0493, 16, rd);
    chk(rd[15:0], 16'hF380);
    cyc(1);
    u_host.sel(1'b1);
    wait_on(1'b1);
    cyc(5);
    i_nrst = 1'b0;
    cyc(3);
    i_nrst = 1'b1;
    cyc(3);
    chk(cfg, 16'h058B);
    cyc(450);
    chk(act, 1'b0);
    report_and_stop();
  end
endmodule
